// ==== core/oscr_regs.sv ====
// oscr_regs: device control and identity registers with the synthesizer start sequencer
// Operation
// - upper five slave address bits from nonvolatile memory
// - select pin sets address low bits
// - revision copied at reset and commit
// - power-down bit gates automatic start
// - setting power-down stops synthesizer, resets calibration
// - clearing power-down restarts synthesizer and calibration
// - trigger rising edge starts calibration
// - trigger clears itself when calibration ends
// - auto-lock decides calibration during reset
// - auto-lock on: lock, then enable outputs
// - power-on, pin, soft bit reset device
// - auto-lock off: halt until host triggers
`timescale 1ns/100ps
module oscr_regs
    import oscr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic reset_pin_n,
    input wire logic addr_sel_high,
    input wire logic addr_sel_low,
    input wire logic nvm_ready,
    input wire logic nvm_commit_done,
    input wire logic [4:0] nvm_addr_hi,
    input wire logic [7:0] nvm_image_revision,
    input wire logic nvm_synth_powerdown,
    input wire logic nvm_auto_lock,
    input wire logic cal_done,
    output logic synth_enable,
    output logic cal_reset,
    output logic cal_start,
    output logic outputs_enable,
    output logic config_busy
);
    // pin synchronisers, second stage is the only reader of the first
    logic [1:0] rpin_sync_reg;
    logic [1:0] ahi_sync_reg;
    logic [1:0] alo_sync_reg;
    // register contents
    logic [4:0] addr_hi_reg, addr_hi_next;
    logic [1:0] addr_lo_reg, addr_lo_next;
    logic [7:0] rev_reg, rev_next;
    logic pdn_reg, pdn_next;
    logic auto_reg, auto_next;
    logic trig_reg, trig_next;
    logic [OSCR_RSV_W-1:0] rsv_reg, rsv_next;
    // sequencer and its outputs
    oscr_sq_state_t sq_reg, sq_next;
    logic start_reg, start_next;
    // serial port strobes
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, wr_ctl, wr_soft, dev_reset;
    logic [6:0] bus_address;
    logic [7:0] ctl_value;

    // three-level pin: both comparators quiet means floating
    function automatic logic [1:0] oscr_addr_sel(input logic hi, input logic lo);
        if (lo) begin
            return OSCR_ASEL_LOW;
        end else if (hi) begin
            return OSCR_ASEL_HIGH;
        end else begin
            return OSCR_ASEL_FLOAT;
        end
    endfunction

    // write strobe decode for one register
    function automatic logic oscr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
        return wr && (a == off);
    endfunction

    // serial slave on the documented two-wire pins
    oscr_serial u_serial (
        .clk_sys(clk_sys),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .dev_addr(bus_address),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rdata(reg_rdata)
    );

    assign bus_address = {addr_hi_reg, addr_lo_reg};
    assign wr_ctl = oscr_hit(reg_wr, reg_addr, OSCR_OFF_DEVICE_CONTROL);
    assign wr_soft = oscr_hit(reg_wr, reg_addr, OSCR_OFF_SOFT_RST)
        && reg_wdata[OSCR_BIT_SOFT_RST];
    // pin low or soft bit both restart configuration
    assign dev_reset = ~rpin_sync_reg[1] | wr_soft;

    // control byte as read back; bit 7 reads zero
    always_comb begin
        ctl_value = '0;
        ctl_value[OSCR_BIT_PDN] = pdn_reg;
        ctl_value[OSCR_RSV_LSB +: OSCR_RSV_W] = rsv_reg;
        ctl_value[OSCR_BIT_TRIG] = trig_reg;
        ctl_value[OSCR_BIT_AUTO] = auto_reg;
    end

    // read mux; unmapped pointers read zero
    always_comb begin
        case (reg_addr)
            OSCR_OFF_BUS_ADDR: reg_rdata = {bus_address, 1'b0};
            OSCR_OFF_IMG_REV: reg_rdata = rev_reg;
            OSCR_OFF_DEVICE_CONTROL: reg_rdata = ctl_value;
            default: reg_rdata = '0;
        endcase
    end

    // next values of registers and sequencer
    always_comb begin
        addr_hi_next = addr_hi_reg;
        addr_lo_next = addr_lo_reg;
        rev_next = rev_reg;
        pdn_next = pdn_reg;
        auto_next = auto_reg;
        trig_next = trig_reg;
        rsv_next = rsv_reg;
        sq_next = sq_reg;
        start_next = 1'b0;
        // commit refreshes the revision at any time
        if (nvm_commit_done) begin
            rev_next = nvm_image_revision;
        end
        if (dev_reset) begin
            // every device reset re-enters configuration
            sq_next = SQ_LOAD;
            trig_next = 1'b0;
        end else begin
            // host writes; load state owns the stored fields
            if (wr_ctl && sq_reg != SQ_LOAD) begin
                pdn_next = reg_wdata[OSCR_BIT_PDN];
                auto_next = reg_wdata[OSCR_BIT_AUTO];
                rsv_next = reg_wdata[OSCR_RSV_LSB +: OSCR_RSV_W];
            end
            case (sq_reg)
                SQ_LOAD: begin
                    // stored image lands before the decision
                    if (nvm_ready) begin
                        addr_hi_next = nvm_addr_hi;
                        addr_lo_next = oscr_addr_sel(ahi_sync_reg[1], alo_sync_reg[1]);
                        rev_next = nvm_image_revision;
                        pdn_next = nvm_synth_powerdown;
                        auto_next = nvm_auto_lock;
                        sq_next = SQ_DECIDE;
                    end
                end
                SQ_DECIDE: begin
                    // trigger is not looked at here, auto-lock
                    if (pdn_reg) begin
                        sq_next = SQ_OFF;
                    end else if (auto_reg) begin
                        sq_next = SQ_CAL;
                        start_next = 1'b1;
                    end else begin
                        sq_next = SQ_HALT;
                    end
                end
                SQ_OFF: begin
                    // leaving power-down recalibrates
                    if (wr_ctl && !reg_wdata[OSCR_BIT_PDN]) begin
                        sq_next = SQ_CAL;
                        start_next = 1'b1;
                    end
                end
                SQ_HALT, SQ_CAL, SQ_RUN: begin
                    if (wr_ctl && reg_wdata[OSCR_BIT_PDN]) begin
                        // power-down aborts pending calibration
                        sq_next = SQ_OFF;
                        trig_next = 1'b0;
                    end else if (wr_ctl && reg_wdata[OSCR_BIT_TRIG] && !trig_reg) begin
                        // only a 0 to 1 write counts
                        sq_next = SQ_CAL;
                        start_next = 1'b1;
                        trig_next = 1'b1;
                    end else if (sq_reg == SQ_CAL && cal_done) begin
                        // finished: self-clear and release outputs
                        sq_next = SQ_RUN;
                        trig_next = 1'b0;
                    end
                end
                default: begin
                    sq_next = SQ_LOAD;
                end
            endcase
        end
    end

    // outputs decode the registered sequencer state; only cal_start is itself registered
    assign synth_enable = (sq_reg == SQ_CAL) || (sq_reg == SQ_RUN);
    assign cal_reset = (sq_reg == SQ_OFF) || (sq_reg == SQ_LOAD);
    assign cal_start = start_reg;
    assign outputs_enable = (sq_reg == SQ_RUN);
    assign config_busy = (sq_reg == SQ_LOAD) || (sq_reg == SQ_DECIDE);

    // state registers; power-on is the async reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rpin_sync_reg <= 2'h0;
            ahi_sync_reg <= 2'h0;
            alo_sync_reg <= 2'h0;
            addr_hi_reg <= OSCR_RST_ADDR_HI;
            addr_lo_reg <= OSCR_ASEL_LOW;
            rev_reg <= OSCR_RST_IMG_REV;
            pdn_reg <= OSCR_RST_PDN;
            auto_reg <= OSCR_RST_AUTO;
            trig_reg <= 1'b0;
            rsv_reg <= '0;
            sq_reg <= SQ_LOAD;
            start_reg <= 1'b0;
        end else begin
            rpin_sync_reg <= {rpin_sync_reg[0], reset_pin_n};
            ahi_sync_reg <= {ahi_sync_reg[0], addr_sel_high};
            alo_sync_reg <= {alo_sync_reg[0], addr_sel_low};
            addr_hi_reg <= addr_hi_next;
            addr_lo_reg <= addr_lo_next;
            rev_reg <= rev_next;
            pdn_reg <= pdn_next;
            auto_reg <= auto_next;
            trig_reg <= trig_next;
            rsv_reg <= rsv_next;
            sq_reg <= sq_next;
            start_reg <= start_next;
        end
    end
endmodule

// ==== pkg/oscr_pkg.sv ====
// oscr_pkg: register map, field layout and encodings of the oscillator control bank
package oscr_pkg;
    // register pointer values seen on the serial port
    localparam logic [7:0] OSCR_OFF_BUS_ADDR = 8'h08;
    localparam logic [7:0] OSCR_OFF_IMG_REV = 8'h09;
    localparam logic [7:0] OSCR_OFF_DEVICE_CONTROL = 8'h0a;
    localparam logic [7:0] OSCR_OFF_SOFT_RST = 8'h48;
    // device_control field positions
    localparam int OSCR_BIT_PDN = 6;
    localparam int OSCR_BIT_TRIG = 1;
    localparam int OSCR_BIT_AUTO = 0;
    localparam int OSCR_RSV_LSB = 2;
    localparam int OSCR_RSV_W = 4;
    // soft reset register field position
    localparam int OSCR_BIT_SOFT_RST = 1;
    // reset values
    localparam logic [7:0] OSCR_RST_IMG_REV = 8'h00;
    localparam logic OSCR_RST_AUTO = 1'b1;
    localparam logic OSCR_RST_PDN = 1'b0;
    localparam logic [4:0] OSCR_RST_ADDR_HI = 5'h16;
    // low address bits from the three-level select pin
    localparam logic [1:0] OSCR_ASEL_LOW = 2'h0;
    localparam logic [1:0] OSCR_ASEL_FLOAT = 2'h1;
    localparam logic [1:0] OSCR_ASEL_HIGH = 2'h3;
    // serial port byte and bit-count layout
    localparam logic [3:0] OSCR_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] OSCR_LAST_BIT = 4'h7;
    // serial slave states
    typedef enum logic [3:0] {
        SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_PTR, SL_PTR_ACK,
        SL_WDATA, SL_WDATA_ACK, SL_RDATA, SL_RDATA_ACK
    } oscr_sl_state_t;
    // synthesizer sequencer states
    typedef enum logic [2:0] {
        SQ_LOAD, SQ_DECIDE, SQ_HALT, SQ_CAL, SQ_RUN, SQ_OFF
    } oscr_sq_state_t;
endpackage

// ==== core/oscr_serial.sv ====
// oscr_serial: two-wire serial slave that turns bus traffic into register strobes
`timescale 1ns/100ps
module oscr_serial
    import oscr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [6:0] dev_addr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    input wire logic [7:0] reg_rdata
);
    // two-stage synchronisers; only stage two is looked at
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    // protocol state
    oscr_sl_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] ptr_reg, ptr_next;
    logic oe_reg, oe_next;
    logic nack_reg, nack_next;
    logic wr_reg, wr_next;
    // derived line events
    logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;

    // open drain: the line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;
    assign reg_addr = ptr_reg;
    assign reg_wdata = sh_reg;
    assign reg_wr = wr_reg;

    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    // sda moving while scl high marks start or stop
    assign bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // next-state logic of the slave
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        oe_next = oe_reg;
        nack_next = nack_reg;
        wr_next = 1'b0;
        if (bus_stop) begin
            st_next = SL_IDLE;
            oe_next = 1'b0;
        end else if (bus_start) begin
            // repeated start keeps the pointer
            st_next = SL_ADDR;
            cnt_next = '0;
            oe_next = 1'b0;
        end else begin
            case (st_reg)
                SL_ADDR, SL_PTR, SL_WDATA: begin
                    if (scl_rise && cnt_reg != OSCR_BITS_PER_BYTE) begin
                        sh_next = {sh_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == OSCR_BITS_PER_BYTE) begin
                        oe_next = 1'b1;
                        if (st_reg == SL_ADDR) begin
                            // answer only our own address
                            if (sh_reg[7:1] == dev_addr) begin
                                st_next = SL_ADDR_ACK;
                                nack_next = sh_reg[0];
                            end else begin
                                st_next = SL_IDLE;
                                oe_next = 1'b0;
                            end
                        end else if (st_reg == SL_PTR) begin
                            ptr_next = sh_reg;
                            st_next = SL_PTR_ACK;
                        end else begin
                            wr_next = 1'b1;
                            st_next = SL_WDATA_ACK;
                        end
                    end
                end
                SL_ADDR_ACK, SL_PTR_ACK, SL_WDATA_ACK: begin
                    if (scl_fall) begin
                        cnt_next = '0;
                        oe_next = 1'b0;
                        if (st_reg == SL_ADDR_ACK && nack_reg) begin
                            // read direction: drive first data bit
                            st_next = SL_RDATA;
                            sh_next = reg_rdata;
                            oe_next = ~reg_rdata[7];
                        end else if (st_reg == SL_ADDR_ACK) begin
                            st_next = SL_PTR;
                        end else if (st_reg == SL_PTR_ACK) begin
                            st_next = SL_WDATA;
                        end else begin
                            // burst writes walk up the map
                            ptr_next = ptr_reg + 8'h01;
                            st_next = SL_WDATA;
                        end
                    end
                end
                SL_RDATA: begin
                    if (scl_fall) begin
                        cnt_next = cnt_reg + 4'h1;
                        if (cnt_reg == OSCR_LAST_BIT) begin
                            st_next = SL_RDATA_ACK;
                            oe_next = 1'b0;
                        end else begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_next = ~sh_reg[6];
                        end
                    end
                end
                SL_RDATA_ACK: begin
                    if (scl_rise) begin
                        // step early so read data settles before the fall
                        nack_next = sda_s;
                        ptr_next = ptr_reg + 8'h01;
                    end else if (scl_fall) begin
                        cnt_next = '0;
                        if (nack_reg) begin
                            st_next = SL_IDLE;
                        end else begin
                            st_next = SL_RDATA;
                            sh_next = reg_rdata;
                            oe_next = ~reg_rdata[7];
                        end
                    end
                end
                default: begin
                    st_next = SL_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    // registers of the slave
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            st_reg <= SL_IDLE;
            cnt_reg <= '0;
            sh_reg <= '0;
            ptr_reg <= '0;
            oe_reg <= 1'b0;
            nack_reg <= 1'b0;
            wr_reg <= 1'b0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            ptr_reg <= ptr_next;
            oe_reg <= oe_next;
            nack_reg <= nack_next;
            wr_reg <= wr_next;
        end
    end
endmodule

// ==== testbench/oscr_regs_checker.sv ====
// oscr_regs_checker: port-level assertions on the oscillator control bank
`timescale 1ns/100ps
module oscr_regs_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sda_out,
    input wire logic reset_pin_n,
    input wire logic nvm_synth_powerdown,
    input wire logic nvm_auto_lock,
    input wire logic cal_done,
    input wire logic synth_enable,
    input wire logic cal_reset,
    input wire logic cal_start,
    input wire logic outputs_enable,
    input wire logic config_busy
);
    // one clock domain, so one clocking and one disable for all
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // open-drain data pin only ever pulls low
    property p_sda_low;
        sda_out == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("data pin value not low");
    // pin held low three samples forces configuration
    property p_pin_reset;
        !reset_pin_n [*3] |=> config_busy && cal_reset;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset not taken");
    // auto-lock on and powerdown off: calibration follows configuration
    property p_auto_cal;
        $fell(config_busy) && $past(nvm_auto_lock) && !$past(nvm_synth_powerdown)
            |-> synth_enable && cal_start;
    endproperty
    a_auto_cal: assert property (p_auto_cal) else $error("no auto calibration");
    // auto-lock off: device halts with synthesizer idle
    property p_halt;
        $fell(config_busy) && !$past(nvm_auto_lock) && !$past(nvm_synth_powerdown)
            |-> !synth_enable && !cal_reset && !cal_start;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt after configuration");
    // stored powerdown keeps synthesizer off after configuration
    property p_pdn_start;
        $fell(config_busy) && $past(nvm_synth_powerdown) |-> cal_reset && !synth_enable;
    endproperty
    a_pdn_start: assert property (p_pdn_start) else $error("powerdown ignored");
    // calibration reset holds the synthesizer down
    property p_off;
        cal_reset |-> !synth_enable && !outputs_enable;
    endproperty
    a_off: assert property (p_off) else $error("synthesizer on in reset");
    // leaving power-down restarts calibration
    property p_restart;
        $fell(cal_reset) && !config_busy |-> cal_start && synth_enable;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    // a start is a single pulse inside calibration
    property p_start;
        cal_start |-> synth_enable && !outputs_enable ##1 !cal_start;
    endproperty
    a_start: assert property (p_start) else $error("bad calibration start");
    // finished calibration leads to running outputs
    property p_done;
        synth_enable && !outputs_enable && cal_done |=> outputs_enable || cal_start || cal_reset;
    endproperty
    a_done: assert property (p_done) else $error("done not taken");
    // outputs only run with a live synthesizer
    property p_run;
        outputs_enable |-> synth_enable && !cal_reset && !config_busy;
    endproperty
    a_run: assert property (p_run) else $error("outputs on without lock");
endmodule
bind oscr_regs oscr_regs_checker oscr_regs_checker_i (.clk_sys, .rst, .sda_out, .reset_pin_n,
    .nvm_synth_powerdown, .nvm_auto_lock, .cal_done, .synth_enable, .cal_reset, .cal_start,
    .outputs_enable, .config_busy);

// ==== testbench/oscr_host.sv ====
// oscr_host: two-wire bus host model for the serial port
`timescale 1ns/100ps
module oscr_host (
    input wire logic clk_sys,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic sda_q = 1'b1; // host side of the data line
    // pulled-up line, low while either side pulls
    assign sda = sda_q & ~sda_oe;
    // clock stands high outside frames
    initial scl = 1'b1;
    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // one bit; data moves well after the fall so the slave sync sees it settled
    task automatic bit_io(input logic b, output logic s);
        tk(4);
        sda_q <= b;
        tk(4);
        scl <= 1'b1;
        tk(4);
        s = sda;
        tk(4);
        scl <= 1'b0;
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] b, input logic last, output logic [7:0] s,
        output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s[i]);
        bit_io(last, a);
        ack = ~a;
    endtask
    // start, or repeated start when rep is set
    task automatic start_c(input logic rep);
        if (rep) begin
            tk(4);
            sda_q <= 1'b1;
            tk(4);
            scl <= 1'b1;
            tk(8);
        end
        sda_q <= 1'b0;
        tk(8);
        scl <= 1'b0;
    endtask
    task automatic stop_c();
        tk(4);
        sda_q <= 1'b0;
        tk(4);
        scl <= 1'b1;
        tk(8);
        sda_q <= 1'b1;
        tk(8);
    endtask
    // pointer then one data byte; ack only if all three bytes were taken
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
        output logic ack);
        logic [7:0] s;
        logic k1, k2, k3;
        start_c(1'b0);
        byte_io({a, 1'b0}, 1'b1, s, k1);
        byte_io(p, 1'b1, s, k2);
        byte_io(d, 1'b1, s, k3);
        stop_c();
        ack = k1 & k2 & k3;
    endtask
    // pointer write, repeated start, one byte read ending in a nack
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
        logic [7:0] s;
        logic k;
        start_c(1'b0);
        byte_io({a, 1'b0}, 1'b1, s, k);
        byte_io(p, 1'b1, s, k);
        start_c(1'b1);
        byte_io({a, 1'b1}, 1'b1, s, k);
        byte_io(8'hff, 1'b1, d, k);
        stop_c();
    endtask
endmodule

// ==== testbench/test_oscr_regs.sv ====
// test_oscr_regs: self-checking bench for the oscillator control bank
`timescale 1ns/100ps
module test_oscr_regs;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic addr_sel_high = 1'b0;
    logic addr_sel_low = 1'b1;
    logic nvm_ready = 1'b1;
    logic nvm_commit_done = 1'b0;
    logic [4:0] nvm_addr_hi = 5'h00;
    logic [7:0] nvm_image_revision = 8'h00;
    logic nvm_synth_powerdown = 1'b0;
    logic nvm_auto_lock = 1'b1;
    logic cal_done = 1'b0;
    logic scl, sda, sda_out, sda_oe, synth_enable, cal_reset, cal_start, outputs_enable;
    logic config_busy, ack;
    logic [7:0] rd_val;
    logic [6:0] dev; // expected bus address
    logic [31:0] seed = 32'hb025;
    int cal_wait = 8; // calibration engine delay
    int cal_cnt = 0;
    int miscompares = 0;
    int samples_checked = 0;
    always #20 clk_sys = ~clk_sys;
    oscr_regs oscr_regs_i (.clk_sys, .rst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
        .reset_pin_n, .addr_sel_high, .addr_sel_low, .nvm_ready, .nvm_commit_done,
        .nvm_addr_hi, .nvm_image_revision, .nvm_synth_powerdown, .nvm_auto_lock, .cal_done,
        .synth_enable, .cal_reset, .cal_start, .outputs_enable, .config_busy);
    oscr_host oscr_host_i (.clk_sys, .sda_oe, .scl, .sda);
    // calibration engine stand-in: one done pulse a set time after each start
    always @(posedge clk_sys) begin
        if (cal_start === 1'b1) cal_cnt <= cal_wait;
        else if (cal_cnt != 0) cal_cnt <= cal_cnt - 1;
        cal_done <= (cal_cnt == 1) && (cal_start !== 1'b1);
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // select pin level to low address bits
    function automatic logic [1:0] low_bits(input int s);
        return (s == 0) ? 2'h0 : (s == 1) ? 2'h1 : 2'h3;
    endfunction
    task automatic end_of_test();
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for running outputs (run) or end of configuration
    task automatic wait_sig(input bit run);
        int n;
        n = 0;
        while (((run ? outputs_enable : !config_busy) !== 1'b1) && n < 6000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 6000) begin
            miscompares++;
            end_of_test();
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] p, input logic [7:0] exp);
        oscr_host_i.rd(dev, p, rd_val);
        chk(what, exp, rd_val);
    endtask
    // main sequence: three stored images, the first through power-on reset and the other two through the reset pin
    initial begin
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            @(posedge clk_sys);
            nvm_addr_hi <= seed[4:0];
            nvm_image_revision <= seed[15:8];
            nvm_auto_lock <= (k != 1);
            nvm_synth_powerdown <= (k == 2);
            addr_sel_low <= (k == 0);
            addr_sel_high <= (k == 2);
            dev = {seed[4:0], low_bits(k)};
            repeat (16) @(posedge clk_sys);
            if (k == 0) rst <= 1'b0;
            else reset_pin_n <= 1'b0;
            repeat (4) @(posedge clk_sys);
            reset_pin_n <= 1'b1;
            repeat (4) @(posedge clk_sys);
            wait_sig(1'b0);
            rd_chk("bus address", 8'h08, {dev, 1'b0});
            rd_chk("revision", 8'h09, seed[15:8]);
            rd_chk("control", 8'h0a, {1'b0, k == 2, 5'h00, k != 1});
            if (k == 0) begin
                wait_sig(1'b1);
                nvm_image_revision <= ~seed[15:8];
                nvm_commit_done <= 1'b1;
                @(posedge clk_sys);
                nvm_commit_done <= 1'b0;
                rd_chk("committed revision", 8'h09, ~seed[15:8]);
                rd_chk("unmapped", 8'h05, 8'h00);
                oscr_host_i.wr(dev, 8'h08, seed[23:16], ack);
                rd_chk("read-only address", 8'h08, {dev, 1'b0});
                oscr_host_i.wr(dev ^ 7'h01, 8'h0a, 8'h40, ack);
                chk("foreign address ack", 8'h00, 8'(ack));
                rd_chk("control kept", 8'h0a, 8'h01);
            end else if (k == 1) begin
                chk("halted synth", 8'h00, 8'(synth_enable | outputs_enable));
                cal_wait = 3000;
                oscr_host_i.wr(dev, 8'h0a, 8'h02, ack);
                chk("write ack", 8'h01, 8'(ack));
                rd_chk("trigger pending", 8'h0a, 8'h02);
                chk("synth on", 8'h01, 8'(synth_enable));
                wait_sig(1'b1);
                cal_wait = 8;
                rd_chk("trigger cleared", 8'h0a, 8'h00);
            end else begin
                chk("stored powerdown", 8'h01, 8'(cal_reset & ~synth_enable));
                oscr_host_i.wr(dev, 8'h0a, 8'h01, ack);
                wait_sig(1'b1);
                oscr_host_i.wr(dev, 8'h0a, 8'h41, ack);
                chk("powered down", 8'h01, 8'(cal_reset & ~outputs_enable));
                rd_chk("pdn readback", 8'h0a, 8'h41);
                // soft reset must reload the changed stored bits
                nvm_auto_lock <= 1'b0;
                nvm_synth_powerdown <= 1'b0;
                oscr_host_i.wr(dev, 8'h48, 8'h02, ack);
                repeat (8) @(posedge clk_sys);
                rd_chk("reloaded control", 8'h0a, 8'h00);
                chk("halt after soft reset", 8'h00, 8'(synth_enable));
            end
        end
        end_of_test();
    end
endmodule
